// File: verilog/svi_device.sv
// device end: pending bits, enables, global enable and the interrupt machine cycle
// assumes the core end issues one operation at a time and waits for op_done
`timescale 1ns/1ps
module svi_device #(
    parameter int          NSRC     = 14,
    parameter logic [15:0] VEC_INIT = svi_pkg::VEC_RESET
) (
    input  wire logic            pclk,
    input  wire logic            presetn,
    svi_if.dev                   lnk,
    input  wire logic [NSRC-1:0] src_req,
    output logic [NSRC-1:0]      pending,
    output logic                 global_en
);
    if (NSRC != svi_pkg::NUM_SRC) begin : g_bad_nsrc
        $error("svi_device serves fourteen sources");
    end

    typedef enum logic [2:0] {
        S_IDLE, S_CLR, S_PUSH_LO, S_PUSH_HI, S_PUSH_FL, S_FETCH_HI, S_FETCH_LO, S_DONE
    } svi_state_t;

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    svi_state_t      state_q;
    logic [7:0]      sys_mode_q;
    logic [15:0]     pend_q;
    logic [15:0]     src_en_q;
    logic [15:0]     vec_rom_q;
    logic [15:0]     vec_q;
    logic [7:0]      push_data_q;
    logic            push_q;
    logic            done_q;
    logic            ack_q;
    logic [7:0]      rdata_q;
    logic [15:0]     ret_pc_q;
    logic [7:0]      ret_flags_q;
    logic [7:0]      st_top;
    logic [7:0]      st_next;
    logic [7:0]      st_third;
    logic            eligible;
    logic            is_wr;
    logic            is_return;
    logic            take;

    svi_stack #(.DEPTH(8)) u_stack (
        .pclk       (pclk),
        .presetn    (presetn),
        .push       (push_q),
        .push_data  (push_data_q),
        .pop        (is_return),
        .top_data   (st_top),
        .next_data  (st_next),
        .third_data (st_third)
    );

    // ------------------------------------------------------------
    // eligibility and acceptance
    // ------------------------------------------------------------
    assign eligible = sys_mode_q[svi_pkg::GIE_BIT]
                      && |(pend_q[NSRC-1:0] & src_en_q[NSRC-1:0]);
    assign take = lnk.op_valid && state_q == S_IDLE
                  && lnk.op == svi_pkg::CMD_STEP && eligible;
    assign is_wr = lnk.op_valid && state_q == S_IDLE && lnk.op == svi_pkg::CMD_WR;
    assign is_return = lnk.op_valid && state_q == S_IDLE && lnk.op == svi_pkg::CMD_RETURN;

    function automatic logic [7:0] clr_byte(input logic [7:0] old, input logic [7:0] wd,
                                             input logic [7:0] set);
        clr_byte = (old & wd) | set;
    endfunction

    // ------------------------------------------------------------
    // pending bits; new requests win over a clearing write
    // ------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pend_q <= 16'h0000;
        end else if (is_wr && lnk.op_addr == svi_pkg::PEND1_ADDR) begin
            pend_q[7:0]  <= clr_byte(pend_q[7:0], lnk.op_wdata, src_req[7:0]);
            pend_q[13:8] <= pend_q[13:8] | src_req[13:8];
        end else if (is_wr && lnk.op_addr == svi_pkg::PEND2_ADDR) begin
            pend_q[7:0]  <= pend_q[7:0] | src_req[7:0];
            pend_q[15:8] <= clr_byte(pend_q[15:8], lnk.op_wdata,
                                     {2'b00, src_req[13:8]});
        end else begin
            pend_q[13:0] <= pend_q[13:0] | src_req;
        end
    end

    // ------------------------------------------------------------
    // system mode, source enables, vector words
    // ------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sys_mode_q <= svi_pkg::SYS_MODE_RESET;
        end else if (state_q == S_CLR) begin
            sys_mode_q[svi_pkg::GIE_BIT] <= 1'b0;
        end else if (lnk.op_valid && state_q == S_IDLE) begin
            unique case (lnk.op)
                svi_pkg::CMD_GIE_ON:  sys_mode_q[svi_pkg::GIE_BIT] <= 1'b1;
                svi_pkg::CMD_GIE_OFF: sys_mode_q[svi_pkg::GIE_BIT] <= 1'b0;
                svi_pkg::CMD_RETURN:  sys_mode_q[svi_pkg::GIE_BIT] <= 1'b1;
                svi_pkg::CMD_WR: begin
                    if (lnk.op_addr == svi_pkg::SYS_MODE_ADDR) begin
                        sys_mode_q <= lnk.op_wdata;
                    end
                end
                default: ;
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            src_en_q  <= 16'h0000;
            vec_rom_q <= VEC_INIT;
        end else if (is_wr) begin
            if (lnk.op_addr == svi_pkg::SRC_EN1_ADDR) src_en_q[7:0]  <= lnk.op_wdata;
            if (lnk.op_addr == svi_pkg::SRC_EN2_ADDR) src_en_q[15:8] <= lnk.op_wdata;
            if (lnk.op_addr == svi_pkg::VEC_HI_ADDR[7:0]) vec_rom_q[15:8] <= lnk.op_wdata;
            if (lnk.op_addr == svi_pkg::VEC_LO_ADDR[7:0]) vec_rom_q[7:0]  <= lnk.op_wdata;
        end
    end

    // ------------------------------------------------------------
    // interrupt machine cycle
    // ------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_q     <= S_IDLE;
            push_q      <= 1'b0;
            push_data_q <= 8'h00;
            vec_q       <= 16'h0000;
            ack_q       <= 1'b0;
        end else begin
            push_q <= 1'b0;
            ack_q  <= 1'b0;
            unique case (state_q)
                S_IDLE: if (take) begin
                    state_q <= S_CLR;
                    ack_q   <= 1'b1;
                end
                S_CLR: begin
                    state_q     <= S_PUSH_LO;
                    push_q      <= 1'b1;
                    push_data_q <= lnk.op_pc[7:0];
                end
                S_PUSH_LO: begin
                    state_q     <= S_PUSH_HI;
                    push_q      <= 1'b1;
                    push_data_q <= lnk.op_pc[15:8];
                end
                S_PUSH_HI: begin
                    state_q     <= S_PUSH_FL;
                    push_q      <= 1'b1;
                    push_data_q <= lnk.op_flags;
                end
                S_PUSH_FL: state_q <= S_FETCH_HI;
                S_FETCH_HI: begin
                    state_q     <= S_FETCH_LO;
                    vec_q[15:8] <= vec_rom_q[15:8];
                end
                S_FETCH_LO: begin
                    state_q    <= S_DONE;
                    vec_q[7:0] <= vec_rom_q[7:0];
                end
                S_DONE: state_q <= S_IDLE;
            endcase
        end
    end

    // ------------------------------------------------------------
    // answers to the core end
    // ------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            done_q      <= 1'b0;
            rdata_q     <= 8'h00;
            ret_pc_q    <= 16'h0000;
            ret_flags_q <= 8'h00;
        end else begin
            done_q <= (lnk.op_valid && state_q == S_IDLE && !take && !done_q)
                      || state_q == S_DONE;
            if (is_return) begin
                ret_pc_q    <= {st_next, st_third};
                ret_flags_q <= st_top;
            end
            if (lnk.op_valid && state_q == S_IDLE && lnk.op == svi_pkg::CMD_RD) begin
                unique case (lnk.op_addr)
                    svi_pkg::SYS_MODE_ADDR: rdata_q <= sys_mode_q;
                    svi_pkg::PEND1_ADDR:    rdata_q <= pend_q[7:0];
                    svi_pkg::PEND2_ADDR:    rdata_q <= pend_q[15:8];
                    svi_pkg::SRC_EN1_ADDR:  rdata_q <= src_en_q[7:0];
                    svi_pkg::SRC_EN2_ADDR:  rdata_q <= src_en_q[15:8];
                    default:                rdata_q <= 8'h00;
                endcase
            end
        end
    end

    assign lnk.op_done    = done_q;
    assign lnk.op_rdata   = rdata_q;
    assign lnk.ack        = ack_q;
    assign lnk.push_valid = push_q;
    assign lnk.push_data  = push_data_q;
    assign lnk.fetch_addr = (state_q == S_FETCH_LO) ? svi_pkg::VEC_LO_ADDR
                                                    : svi_pkg::VEC_HI_ADDR;
    assign lnk.vector     = vec_q;
    assign lnk.ret_pc     = ret_pc_q;
    assign lnk.ret_flags  = ret_flags_q;
    assign pending        = pend_q[NSRC-1:0];
    assign global_en      = sys_mode_q[svi_pkg::GIE_BIT];
endmodule // svi_device

// File: verilog/svi_pkg.sv
// constants for the single vector interrupt unit
// assumes one clock pclk and an active low asynchronous reset presetn
package svi_pkg;
    // ------------------------------------------------------------
    // register map of the device end
    // ------------------------------------------------------------
    localparam logic [7:0] SYS_MODE_ADDR    = 8'hdf;
    localparam int         GIE_BIT          = 3;
    localparam logic [7:0] PEND1_ADDR       = 8'hd0;
    localparam logic [7:0] PEND2_ADDR       = 8'hd1;
    localparam logic [7:0] SRC_EN1_ADDR     = 8'hd2;
    localparam logic [7:0] SRC_EN2_ADDR     = 8'hd3;
    localparam logic [7:0] SYS_MODE_RESET   = 8'h00;
    localparam int         WATCH_BIT        = 11;
    localparam int         NUM_SRC          = 14;
    localparam logic [15:0] VEC_HI_ADDR     = 16'h0000;
    localparam logic [15:0] VEC_LO_ADDR     = 16'h0001;
    localparam logic [15:0] VEC_RESET       = 16'h0100;
    // ------------------------------------------------------------
    // apb register map of the controller end
    // ------------------------------------------------------------
    localparam logic [7:0] A_CMD    = 8'h00;
    localparam logic [7:0] A_STAT   = 8'h04;
    localparam logic [7:0] A_IRQ    = 8'h08;
    localparam logic [7:0] A_MASK   = 8'h0c;
    localparam logic [7:0] A_PC     = 8'h10;
    localparam logic [7:0] A_FLAGS  = 8'h14;
    localparam logic [7:0] A_REGADR = 8'h18;
    localparam logic [7:0] A_REGDAT = 8'h1c;
    localparam logic [7:0] A_SEL    = 8'h20;
    // command codes written to A_CMD
    localparam logic [2:0] CMD_STEP    = 3'h1;
    localparam logic [2:0] CMD_GIE_ON  = 3'h2;
    localparam logic [2:0] CMD_GIE_OFF = 3'h3;
    localparam logic [2:0] CMD_RETURN  = 3'h4;
    localparam logic [2:0] CMD_WR      = 3'h5;
    localparam logic [2:0] CMD_RD      = 3'h6;
    // irq status bits
    localparam int EV_ENTRY = 0;
    localparam int EV_DONE  = 1;
    localparam int EV_RET   = 2;

    typedef enum logic [2:0] {
        OP_NONE, OP_STEP, OP_GIE_ON, OP_GIE_OFF, OP_RETURN, OP_WR, OP_RD
    } svi_op_t;
endpackage

// File: verilog/svi_if.sv
// link between the interrupt device end and the core sequencer end
// assumes both ends share pclk
`timescale 1ns/1ps
interface svi_if;
    logic        op_valid;
    logic [2:0]  op;
    logic [7:0]  op_addr;
    logic [7:0]  op_wdata;
    logic [15:0] op_pc;
    logic [7:0]  op_flags;
    logic        op_done;
    logic [7:0]  op_rdata;
    logic        ack;
    logic        push_valid;
    logic [7:0]  push_data;
    logic [15:0] fetch_addr;
    logic [15:0] vector;
    logic [15:0] ret_pc;
    logic [7:0]  ret_flags;

    modport dev (
        input  op_valid, op, op_addr, op_wdata, op_pc, op_flags,
        output op_done, op_rdata, ack, push_valid, push_data, fetch_addr, vector,
               ret_pc, ret_flags
    );
    modport core (
        output op_valid, op, op_addr, op_wdata, op_pc, op_flags,
        input  op_done, op_rdata, ack, push_valid, push_data, fetch_addr, vector,
               ret_pc, ret_flags
    );
endinterface // svi_if

// File: verilog/svi_stack.sv
// small byte stack used by the device end for interrupt entry and return
// assumes pushes and pops never happen in the same cycle
`timescale 1ns/1ps
module svi_stack #(
    parameter int DEPTH = 8
) (
    input  wire logic       pclk,
    input  wire logic       presetn,
    input  wire logic       push,
    input  wire logic [7:0] push_data,
    input  wire logic       pop,
    output logic [7:0]      top_data,
    output logic [7:0]      next_data,
    output logic [7:0]      third_data
);
    if (DEPTH < 4 || (DEPTH & (DEPTH - 1)) != 0) begin : g_bad_depth
        $error("svi_stack depth must be a power of two of at least four");
    end
    logic [7:0] mem_q [DEPTH];
    logic [$clog2(DEPTH)-1:0] sp_q;

    function automatic logic [$clog2(DEPTH)-1:0] idx(input int off);
        idx = sp_q - off[$clog2(DEPTH)-1:0];
    endfunction

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sp_q <= '0;
        end else if (push) begin
            sp_q <= sp_q + 1'b1;
        end else if (pop) begin
            sp_q <= sp_q - 2'd3;
        end
    end

    always_ff @(posedge pclk) begin
        if (push) begin
            mem_q[sp_q] <= push_data;
        end
    end

    assign top_data   = mem_q[idx(1)];
    assign next_data  = mem_q[idx(2)];
    assign third_data = mem_q[idx(3)];
endmodule // svi_stack

// File: verilog/svi_core.sv
// core sequencer end: takes orders over apb and drives operations to the device end
// assumes a single apb master
`timescale 1ns/1ps
module svi_core (
    input  wire logic        pclk,
    input  wire logic        presetn,
    svi_if.core              lnk,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    output logic             irq
);
    logic        busy_q;
    logic [2:0]  op_q;
    logic [7:0]  regadr_q;
    logic [7:0]  regdat_q;
    logic [15:0] pc_q;
    logic [7:0]  flags_q;
    logic [2:0]  stat_q;
    logic [2:0]  mask_q;
    logic [7:0]  rd_q;
    logic        entered_q;
    logic        wr;
    logic        rd;
    logic [2:0]  ev;

    assign wr = psel && penable && pwrite;
    assign rd = psel && penable && !pwrite;

    // ------------------------------------------------------------
    // command issue, one operation at a time
    // ------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            busy_q   <= 1'b0;
            op_q     <= 3'h0;
            regadr_q <= 8'h00;
            regdat_q <= 8'h00;
            pc_q     <= 16'h0000;
            flags_q  <= 8'h00;
            rd_q     <= 8'h00;
        end else begin
            if (wr && !busy_q && paddr == svi_pkg::A_CMD) begin
                busy_q <= 1'b1;
                op_q   <= pwdata[2:0];
            end else if (lnk.op_done) begin
                busy_q <= 1'b0;
                if (op_q == svi_pkg::CMD_RD) rd_q <= lnk.op_rdata;
                if (op_q == svi_pkg::CMD_STEP && entered_q) pc_q <= lnk.vector;
                if (op_q == svi_pkg::CMD_RETURN) begin
                    pc_q    <= lnk.ret_pc;
                    flags_q <= lnk.ret_flags;
                end
            end
            if (wr && paddr == svi_pkg::A_PC)     pc_q     <= pwdata[15:0];
            if (wr && paddr == svi_pkg::A_FLAGS)  flags_q  <= pwdata[7:0];
            if (wr && paddr == svi_pkg::A_REGADR) regadr_q <= pwdata[7:0];
            if (wr && paddr == svi_pkg::A_REGDAT) regdat_q <= pwdata[7:0];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            entered_q <= 1'b0;
        end else if (lnk.ack) begin
            entered_q <= 1'b1;
        end else if (lnk.op_done) begin
            entered_q <= 1'b0;
        end
    end

    assign lnk.op_valid = busy_q && !lnk.op_done;
    assign lnk.op       = op_q;
    assign lnk.op_addr  = regadr_q;
    assign lnk.op_wdata = regdat_q;
    assign lnk.op_pc    = pc_q;
    assign lnk.op_flags = flags_q;

    // ------------------------------------------------------------
    // events, read-to-clear status, mask, interrupt
    // ------------------------------------------------------------
    assign ev[svi_pkg::EV_ENTRY] = lnk.ack;
    assign ev[svi_pkg::EV_DONE]  = lnk.op_done;
    assign ev[svi_pkg::EV_RET]   = lnk.op_done && op_q == svi_pkg::CMD_RETURN;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            stat_q <= 3'h0;
            mask_q <= 3'h0;
        end else begin
            if (rd && paddr == svi_pkg::A_IRQ) stat_q <= ev;
            else stat_q <= stat_q | ev;
            if (wr && paddr == svi_pkg::A_MASK) mask_q <= pwdata[2:0];
        end
    end
    assign irq = |(stat_q & mask_q);

    // ------------------------------------------------------------
    // apb read mux
    // ------------------------------------------------------------
    always_comb begin
        prdata = 32'h0000_0000;
        unique case (paddr)
            svi_pkg::A_CMD:    prdata = {29'h0, op_q};
            svi_pkg::A_STAT:   prdata = {23'h0, entered_q, rd_q};
            svi_pkg::A_IRQ:    prdata = {29'h0, stat_q};
            svi_pkg::A_MASK:   prdata = {29'h0, mask_q};
            svi_pkg::A_PC:     prdata = {16'h0, pc_q};
            svi_pkg::A_FLAGS:  prdata = {24'h0, flags_q};
            svi_pkg::A_REGADR: prdata = {24'h0, regadr_q};
            svi_pkg::A_REGDAT: prdata = {24'h0, regdat_q};
            svi_pkg::A_SEL:    prdata = {31'h0, busy_q};
            default:           prdata = 32'h0000_0000;
        endcase
    end
    assign pready  = 1'b1;
    assign pslverr = psel && penable && (paddr[1:0] != 2'b00 || paddr > svi_pkg::A_SEL);
endmodule // svi_core

// File: sim/svi_properties.sv
// checker for the link between the interrupt device end and the core end
// assumes one clock pclk and the active low reset presetn of both ends
`timescale 1ns/1ps
module svi_properties #(
    parameter int NSRC = 14
) (
    input wire logic            pclk,
    input wire logic            presetn,
    input wire logic            op_valid,
    input wire logic [2:0]      op,
    input wire logic [15:0]     op_pc,
    input wire logic [7:0]      op_flags,
    input wire logic            op_done,
    input wire logic            ack,
    input wire logic            push_valid,
    input wire logic [7:0]      push_data,
    input wire logic [15:0]     fetch_addr,
    input wire logic [NSRC-1:0] src_req,
    input wire logic [NSRC-1:0] pending,
    input wire logic            global_en
);
    // ------------------------------------------------------------
    // link properties
    // ------------------------------------------------------------
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    a_ack_single_pulse: assert property (ack |=> !ack)
        else $error("ack longer than one cycle");
    a_ack_needs_gie: assert property (ack |-> $past(global_en) || $past(global_en, 2))
        else $error("ack without global enable");
    a_entry_clears_gie: assert property (ack |-> ##[0:1] !global_en)
        else $error("global enable kept on entry");
    a_push_three_bytes: assert property (ack |-> ##[1:2]
        (push_valid && push_data == op_pc[7:0]) ##1
        (push_valid && push_data == op_pc[15:8]) ##1
        (push_valid && push_data == op_flags))
        else $error("entry pushes wrong order or data");
    a_vector_fetch_order: assert property (ack |-> ##4
        (fetch_addr == svi_pkg::VEC_HI_ADDR) ##1 (fetch_addr == svi_pkg::VEC_LO_ADDR))
        else $error("vector fetched out of order");
    a_done_single: assert property (op_done |=> !op_done)
        else $error("op done longer than one cycle");
    a_req_sets_pend: assert property (|src_req |=> ((pending & $past(src_req)) == $past(src_req)))
        else $error("request did not set pending");
    a_pend_clear_write: assert property (|($past(pending) & ~pending)
        |-> $past(op_valid) || $past(op_valid, 2))
        else $error("pending cleared without a write");
    a_gie_rise_op: assert property ($rose(global_en)
        |-> $past(op_valid) || $past(op_valid, 2))
        else $error("global enable rose without an operation");
endmodule // svi_properties

// File: sim/single_vector_interrupt_unit_test.sv
// testbench for the single vector interrupt unit, both ends joined by svi_if
// assumes the apb register map and command codes of svi_pkg
`timescale 1ns/1ps
module single_vector_interrupt_unit_test;
    logic        pclk = 1'b0;
    logic        presetn = 1'b0;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        irq;
    logic [13:0] src_req = 14'h0;
    logic [13:0] pending;
    logic        global_en;
    logic [31:0] rd;
    logic        slv;
    logic [7:0]  pushed[$];
    int          failures = 0;
    int          check_count = 0;

    always #25 pclk = ~pclk;
    svi_if lnk_if ();
    svi_device svi_device_inst (.pclk(pclk), .presetn(presetn), .lnk(lnk_if),
        .src_req(src_req), .pending(pending), .global_en(global_en));
    svi_core svi_core_inst (.pclk(pclk), .presetn(presetn), .lnk(lnk_if), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(irq));
    svi_properties svi_properties_inst (.pclk(pclk), .presetn(presetn),
        .op_valid(lnk_if.op_valid), .op(lnk_if.op), .op_pc(lnk_if.op_pc),
        .op_flags(lnk_if.op_flags), .op_done(lnk_if.op_done), .ack(lnk_if.ack),
        .push_valid(lnk_if.push_valid), .push_data(lnk_if.push_data),
        .fetch_addr(lnk_if.fetch_addr),
        .src_req(src_req), .pending(pending), .global_en(global_en));

    always @(posedge pclk) begin
        if (lnk_if.push_valid === 1'b1) pushed.push_back(lnk_if.push_data);
    end
    // ------------------------------------------------------------
    // tasks
    // ------------------------------------------------------------
    task automatic summarize();
        if (failures == 0 && check_count > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            failures++;
            $display("[FAIL] %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        rd  = prdata;
        slv = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask
    task automatic cmd(input logic [2:0] code);
        apb(1'b1, svi_pkg::A_CMD, {29'h0, code});
        do begin
            apb(1'b0, svi_pkg::A_SEL, 32'h0);
        end while (rd[0] !== 1'b0);
    endtask
    task automatic dev_wr(input logic [7:0] a, input logic [7:0] d);
        apb(1'b1, svi_pkg::A_REGADR, {24'h0, a});
        apb(1'b1, svi_pkg::A_REGDAT, {24'h0, d});
        cmd(svi_pkg::CMD_WR);
    endtask
    task automatic dev_rd(input logic [7:0] a);
        apb(1'b1, svi_pkg::A_REGADR, {24'h0, a});
        cmd(svi_pkg::CMD_RD);
        apb(1'b0, svi_pkg::A_STAT, 32'h0);
    endtask
    task automatic pulse(input int i);
        src_req[i] <= 1'b1;
        @(posedge pclk);
        src_req <= 14'h0;
        @(posedge pclk);
    endtask
    // ------------------------------------------------------------
    // tests
    // ------------------------------------------------------------
    initial begin
        repeat (20000) @(posedge pclk);
        failures++;
        summarize();
    end
    initial begin
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        dev_rd(svi_pkg::SYS_MODE_ADDR);
        chk("sys mode reset", {24'h0, rd[7:0]}, {24'h0, svi_pkg::SYS_MODE_RESET});
        chk("gie after reset", global_en, 32'h0);
        dev_wr(svi_pkg::SRC_EN1_ADDR, 8'hff);
        dev_wr(svi_pkg::SRC_EN2_ADDR, 8'h3f);
        apb(1'b1, svi_pkg::A_PC, 32'h1234);
        apb(1'b1, svi_pkg::A_FLAGS, 32'h5a);
        apb(1'b1, svi_pkg::A_MASK, 32'h1);
        pulse(2);
        pulse(0);
        chk("pending set", pending, 32'h5);
        cmd(svi_pkg::CMD_STEP);
        chk("no entry gie off", pushed.size(), 32'h0);
        cmd(svi_pkg::CMD_GIE_ON);
        chk("gie on", global_en, 32'h1);
        dev_rd(svi_pkg::SYS_MODE_ADDR);
        chk("sys mode bit", {24'h0, rd[7:0]}, 32'h8);
        cmd(svi_pkg::CMD_STEP);
        chk("pushes", {pushed[0], pushed[1], pushed[2]}, 32'h34125a);
        chk("gie off entry", global_en, 32'h0);
        chk("pending kept", pending, 32'h5);
        chk("irq raised", irq, 32'h1);
        apb(1'b0, svi_pkg::A_PC, 32'h0);
        chk("branch vector", rd[15:0], {16'h0, svi_pkg::VEC_RESET});
        apb(1'b0, svi_pkg::A_IRQ, 32'h0);
        chk("entry event", rd[2:0], 32'h3);
        chk("irq cleared", irq, 32'h0);
        for (int i = 0; i < svi_pkg::NUM_SRC; i++) pulse(i);
        chk("all sources", pending, 32'h3fff);
        dev_wr(svi_pkg::PEND2_ADDR, 8'hf7);
        chk("watch clear", pending, 32'h37ff);
        dev_wr(svi_pkg::PEND1_ADDR, 8'hfb);
        chk("byte clear", pending, 32'h37fb);
        dev_wr(svi_pkg::PEND1_ADDR, 8'h00);
        dev_wr(svi_pkg::PEND2_ADDR, 8'h00);
        chk("all clear", pending, 32'h0);
        cmd(svi_pkg::CMD_RETURN);
        chk("gie after return", global_en, 32'h1);
        chk("ret pc", lnk_if.ret_pc, 32'h1234);
        chk("ret flags", lnk_if.ret_flags, 32'h5a);
        apb(1'b0, svi_pkg::A_IRQ, 32'h0);
        chk("return event", rd[2:0], 32'h6);
        dev_wr(svi_pkg::SRC_EN1_ADDR, 8'h00);
        pulse(3);
        pushed.delete();
        cmd(svi_pkg::CMD_STEP);
        chk("source disabled", pushed.size(), 32'h0);
        dev_wr(svi_pkg::SRC_EN1_ADDR, 8'h08);
        cmd(svi_pkg::CMD_STEP);
        chk("taken when enabled", pushed.size(), 32'h3);
        cmd(svi_pkg::CMD_GIE_ON);
        cmd(svi_pkg::CMD_GIE_OFF);
        chk("gie off by disable", global_en, 32'h0);
        dev_wr(svi_pkg::VEC_HI_ADDR[7:0], 8'h4c);
        dev_wr(svi_pkg::VEC_LO_ADDR[7:0], 8'h21);
        cmd(svi_pkg::CMD_GIE_ON);
        cmd(svi_pkg::CMD_STEP);
        apb(1'b0, svi_pkg::A_PC, 32'h0);
        chk("shared vector", rd[15:0], 32'h4c21);
        apb(1'b0, 8'h24, 32'h0);
        chk("unmapped", slv, 32'h1);
        summarize();
    end
endmodule // single_vector_interrupt_unit_test
